/* sim/test_tx_modulation_config_regs.sv */
// Self-checking testbench for the TX modulation configuration registers
`timescale 1ns/10ps
`default_nettype none

module test_tx_modulation_config_regs;
  // ----------------------------------------------------------------
  // Signals and bookkeeping
  // ----------------------------------------------------------------
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        target_loadmod;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        regulator_am_active;
  logic [5:0]  regulator_am_depth_pct;
  logic [2:0]  driver_res_norm;
  logic        driver_res_hiz;
  logic        ext_loadmod_pin;
  logic        resistive_am_active;
  logic [6:0]  resistive_am_resistance;
  logic [12:0] target_res_cnorm;
  logic        target_res_hiz;
  logic        target_mod_state;
  logic        rd_dphase;
  logic [31:0] exp_q[$];
  string       name_q[$];
  int          n_errors;
  int          num_checks;
  logic [7:0]  rv;
  logic [7:0]  a;
  int          dep_t [16] = '{5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 17, 19, 22, 26, 40};
  int          drv_t [16] = '{1, 1, 1, 2, 2, 4, 4, 4, 4, 4, 4, 4, 4, 4, 4, 4};
  int          res_t [16] = '{25, 50, 100, 200, 305, 400, 640, 800, 915, 1068, 1280, 1600, 2133, 3200, 6400, 0};

  txmc_regs #(.ADDR_W(8)) u_txmc_regs (
    .hclk                    (hclk),
    .hresetn                 (hresetn),
    .hsel                    (hsel),
    .haddr                   (haddr),
    .htrans                  (htrans),
    .hwrite                  (hwrite),
    .hsize                   (hsize),
    .hwdata                  (hwdata),
    .hready                  (hreadyout),
    .target_loadmod          (target_loadmod),
    .hreadyout               (hreadyout),
    .hresp                   (hresp),
    .hrdata                  (hrdata),
    .regulator_am_active     (regulator_am_active),
    .regulator_am_depth_pct  (regulator_am_depth_pct),
    .driver_res_norm         (driver_res_norm),
    .driver_res_hiz          (driver_res_hiz),
    .ext_loadmod_pin         (ext_loadmod_pin),
    .resistive_am_active     (resistive_am_active),
    .resistive_am_resistance (resistive_am_resistance),
    .target_res_cnorm        (target_res_cnorm),
    .target_res_hiz          (target_res_hiz),
    .target_mod_state        (target_mod_state)
  );

  always #25 hclk = ~hclk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] ba(input logic [5:0] idx);
    return {idx, 2'b00};
  endfunction : ba

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
    num_checks++;
    if (seen !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, seen);
    end
  endtask : chk

  task automatic results;
    if (n_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  // Address phase held until hready is sampled high
  task automatic addr_phase(input logic [7:0] ad, input logic wr);
    hsel   <= 1'b1;
    haddr  <= ad;
    htrans <= 2'b10;
    hwrite <= wr;
    hsize  <= txmc_pkg::HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask : addr_phase

  task automatic bus_wr(input logic [7:0] ad, input logic [7:0] d);
    addr_phase(ad, 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask : bus_wr

  // Notes the expected word; the monitor compares it when the data phase ends
  task automatic bus_rd(input logic [7:0] ad, input logic [31:0] e, input string nm);
    exp_q.push_back(e);
    name_q.push_back(nm);
    addr_phase(ad, 1'b0);
    htrans <= 2'b00;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask : bus_rd

  // Register write lands at one edge, outputs at the next; sampled one later
  task automatic settle;
    repeat (2) @(posedge hclk);
  endtask : settle

  // ----------------------------------------------------------------
  // Read-data monitor
  // ----------------------------------------------------------------
  always @(posedge hclk) begin
    if (rd_dphase === 1'b1 && hreadyout === 1'b1) begin
      chk(name_q.pop_front(), hrdata, exp_q.pop_front());
      chk("hresp", 32'(hresp), 32'h0);
    end
    if (hresetn !== 1'b1) begin
      rd_dphase = 1'b0;
    end else if (hreadyout === 1'b1) begin
      rd_dphase = hsel && htrans[1] && !hwrite;
    end
  end

  initial begin
    repeat (20000) @(posedge hclk);
    n_errors++;
    results();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h0;
    target_loadmod = 1'b0;
    rd_dphase = 1'b0;
    n_errors = 0;
    num_checks = 0;
    void'($urandom(32'h276a12b1));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    settle();
    chk("depth_rst", 32'(regulator_am_depth_pct), 32'd12);
    chk("regam_rst", 32'(regulator_am_active), 32'h1);
    chk("cnorm_rst", 32'(target_res_cnorm), 32'd25);
    chk("pin_rst", 32'(ext_loadmod_pin), 32'h0);
    bus_rd(ba(txmc_pkg::IDX_TX_DRV), 32'h70, "tx_drv_rst");
    bus_rd(ba(txmc_pkg::IDX_TGT_RES), 32'h70, "tgt_rst");
    bus_rd(ba(txmc_pkg::IDX_RSVD_A), 32'h0, "rsvd_a_rst");
    bus_rd(ba(txmc_pkg::IDX_RSVD_B), 32'h0, "rsvd_b_rst");
    bus_rd(ba(txmc_pkg::IDX_STATUS), 32'h4c, "status_rst");
    for (int i = 0; i < 6; i++) begin
      rv = 8'($urandom);
      bus_wr(ba(txmc_pkg::IDX_TX_DRV), rv);
      bus_rd(ba(txmc_pkg::IDX_TX_DRV), {24'h0, rv}, "tx_drv_rw");
      bus_wr(ba(txmc_pkg::IDX_TGT_RES), ~rv);
      bus_rd(ba(txmc_pkg::IDX_TGT_RES), {24'h0, ~rv}, "tgt_rw");
      bus_wr(ba(txmc_pkg::IDX_RSVD_A), rv);
      bus_wr(ba(txmc_pkg::IDX_RSVD_B), ~rv);
      bus_rd(ba(txmc_pkg::IDX_RSVD_A), 32'h0, "rsvd_a_wr");
      bus_rd(ba(txmc_pkg::IDX_RSVD_B), 32'h0, "rsvd_b_wr");
    end
    bus_rd(8'h40, 32'h0, "unmapped");
    for (int i = 0; i < 16; i++) begin
      bus_wr(ba(txmc_pkg::IDX_TX_DRV), {4'(i), 4'(i)});
      settle();
      chk("depth", 32'(regulator_am_depth_pct), 32'(dep_t[i]));
      chk("drv_norm", 32'(driver_res_norm), 32'(drv_t[i]));
      chk("drv_hiz", 32'(driver_res_hiz), 32'(i == 15));
    end
    for (int i = 0; i < 16; i++) begin
      bus_wr(ba(txmc_pkg::IDX_TGT_RES), {4'(i), 4'(15 - i)});
      for (int t = 0; t < 2; t++) begin
        target_loadmod <= t[0];
        settle();
        chk("cnorm", 32'(target_res_cnorm), 32'(res_t[t ? i : 15 - i]));
        chk("tgt_hiz", 32'(target_res_hiz), 32'((t ? i : 15 - i) == 15));
        chk("mod_state", 32'(target_mod_state), 32'(t));
      end
    end
    bus_wr(ba(txmc_pkg::IDX_SPACE_SEL), 8'h01);
    bus_rd(ba(txmc_pkg::IDX_SPACE_SEL), 32'h1, "space_sel");
    bus_rd(ba(txmc_pkg::IDX_AUX_MOD), 32'h10, "aux_rst");
    bus_rd(ba(txmc_pkg::IDX_RAM_RES), 32'h0, "ram_rst");
    rv = 8'($urandom) & 8'h7f;
    bus_wr(ba(txmc_pkg::IDX_RAM_RES), rv);
    bus_rd(ba(txmc_pkg::IDX_RAM_RES), {24'h0, rv}, "ram_rw");
    for (int i = 0; i < 32; i++) begin
      a = {5'(i), 3'b111};
      bus_wr(ba(txmc_pkg::IDX_AUX_MOD), a);
      bus_rd(ba(txmc_pkg::IDX_AUX_MOD), {24'h0, a & 8'hf8}, "aux_rw");
      for (int t = 0; t < 2; t++) begin
        target_loadmod <= t[0];
        settle();
        chk("ext_pin", 32'(ext_loadmod_pin), 32'(a[5] ? (t[0] ^ a[6]) : a[6]));
        chk("regam", 32'(regulator_am_active), 32'(!a[7]));
        chk("resam", 32'(resistive_am_active), 32'(a[3]));
        chk("resam_val", 32'(resistive_am_resistance), 32'(a[3] ? rv[6:0] : 7'h00));
        chk("mod_state", 32'(target_mod_state), 32'(a[4] & t[0]));
        chk("cnorm_aux", 32'(target_res_cnorm), (a[4] && t[0]) ? 32'd0 : 32'd25);
      end
    end
    bus_wr(ba(txmc_pkg::IDX_SPACE_SEL), 8'h00);
    bus_rd(ba(txmc_pkg::IDX_TX_DRV), 32'hff, "tx_drv_space_a");
    repeat (4) @(posedge hclk);
    chk("reads_left", 32'(exp_q.size()), 32'h0);
    results();
  end
endmodule : test_tx_modulation_config_regs

`default_nettype wire

/* src/txmc_decode.sv */
// Decoders from register codes to modulation depth and normalised resistances
`timescale 1ns/10ps
`default_nettype none

module txmc_decode (
  input  wire logic [3:0]  am_idx,
  input  wire logic [3:0]  drv_res,
  input  wire logic [3:0]  tgt_code,
  output logic      [5:0]  depth_pct,
  output logic      [2:0]  drv_norm,
  output logic             drv_hiz,
  output logic      [12:0] tgt_cnorm,
  output logic             tgt_hiz
);

  // ----------------------------------------------------------------
  // Lookup functions
  // ----------------------------------------------------------------
  function automatic logic [5:0] am_pct(input logic [3:0] c);
    logic [5:0] p;
    p = 6'd5 + {2'b00, c};
    unique case (c)
      4'd11:   p = 6'd17;
      4'd12:   p = 6'd19;
      4'd13:   p = 6'd22;
      4'd14:   p = 6'd26;
      4'd15:   p = 6'd40;
      default: p = 6'd5 + {2'b00, c};
    endcase
    return p;
  endfunction : am_pct

  // Hundredths of the unit resistance; code 15 is high impedance
  function automatic logic [12:0] tgt_res(input logic [3:0] c);
    logic [12:0] r;
    r = 13'd0;
    unique case (c)
      4'd0:  r = 13'd25;
      4'd1:  r = 13'd50;
      4'd2:  r = 13'd100;
      4'd3:  r = 13'd200;
      4'd4:  r = 13'd305;
      4'd5:  r = 13'd400;
      4'd6:  r = 13'd640;
      4'd7:  r = 13'd800;
      4'd8:  r = 13'd915;
      4'd9:  r = 13'd1068;
      4'd10: r = 13'd1280;
      4'd11: r = 13'd1600;
      4'd12: r = 13'd2133;
      4'd13: r = 13'd3200;
      4'd14: r = 13'd6400;
      4'd15: r = 13'd0;
    endcase
    return r;
  endfunction : tgt_res

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  always_comb begin
    depth_pct = am_pct(am_idx);
    tgt_cnorm = tgt_res(tgt_code);
    tgt_hiz   = (tgt_code == txmc_pkg::RES_CODE_HZ);
    drv_hiz   = (drv_res == txmc_pkg::RES_CODE_HZ);
    // Codes 0 and 1 are undefined; they fall back to the lowest resistance
    if (drv_res >= 4'd5) begin
      drv_norm = 3'd4;
    end else if (drv_res >= 4'd3) begin
      drv_norm = 3'd2;
    end else begin
      drv_norm = 3'd1;
    end
  end

endmodule : txmc_decode

`default_nettype wire

/* src/txmc_pkg.sv */
// Package: offsets, field layouts and reset values of the TX modulation config registers
package txmc_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_RSVD_A    = 6'h26;
  localparam logic [5:0] IDX_RSVD_B    = 6'h27;
  localparam logic [5:0] IDX_TX_DRV    = 6'h28;  // Space A
  localparam logic [5:0] IDX_AUX_MOD   = 6'h28;  // Space B
  localparam logic [5:0] IDX_TGT_RES   = 6'h29;  // Space A
  localparam logic [5:0] IDX_RAM_RES   = 6'h2a;  // Space B
  localparam logic [5:0] IDX_STATUS    = 6'h3e;
  localparam logic [5:0] IDX_SPACE_SEL = 6'h3f;

  // ----------------------------------------------------------------
  // Reset values and write masks
  // ----------------------------------------------------------------
  localparam logic [7:0] TX_DRV_RST    = 8'h70;
  localparam logic [7:0] AUX_MOD_RST   = 8'h10;
  localparam logic [7:0] TGT_RES_RST   = 8'h70;
  localparam logic [6:0] RAM_RES_RST   = 7'h00;
  localparam logic [7:0] AUX_WR_MASK   = 8'hf8;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int AM_IDX_LSB   = 4;
  localparam int DRV_RES_LSB  = 0;
  localparam int AUX_REG_DIS  = 7;
  localparam int AUX_EXT_POL  = 6;
  localparam int AUX_EXT_EN   = 5;
  localparam int AUX_DRV_LM   = 4;
  localparam int AUX_RSAM_EN  = 3;
  localparam int TGT_MOD_LSB  = 4;
  localparam int TGT_UNM_LSB  = 0;

  // ----------------------------------------------------------------
  // Bus and resistance code encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] HSIZE_WORD  = 3'h2;
  localparam logic [3:0] RES_CODE_HZ = 4'hf;

endpackage : txmc_pkg

/* src/txmc_regs.sv */
// TX modulation configuration registers behind an AHB-Lite slave
// Function
// - AM index codes map to 5-40 percent depth
// - Driver resistance codes select 1, 2, 4, high-Z
// - TX driver resets 0x70, host read/write
// - Aux register shares address, space B
// - Regulator AM disable bit, inverted sense
// - Polarity bit inverts external load-mod pin
// - External pin follows load mod only when enabled
// - Driver load mod uses target resistances
// - Resistive AM uses seven-bit resistance field
// - Target nibbles decode 0.25 to 64, 15 high-Z
// - Reserved registers read zero
`timescale 1ns/10ps
`default_nettype none

module txmc_regs #(
  parameter int ADDR_W = 8
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  input  wire logic              target_loadmod,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic      [31:0]       hrdata,
  output logic                   regulator_am_active,
  output logic      [5:0]        regulator_am_depth_pct,
  output logic      [2:0]        driver_res_norm,
  output logic                   driver_res_hiz,
  output logic                   ext_loadmod_pin,
  output logic                   resistive_am_active,
  output logic      [6:0]        resistive_am_resistance,
  output logic      [12:0]       target_res_cnorm,
  output logic                   target_res_hiz,
  output logic                   target_mod_state
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (ADDR_W < 8) begin : g_addr_chk
    $error("txmc_regs: ADDR_W must be at least 8");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0]  tx_drv_ff;
  logic [7:0]  aux_mod_ff;
  logic [7:0]  tgt_res_ff;
  logic [6:0]  ram_res_ff;
  logic        space_b_ff;
  logic        wr_pend_ff;
  logic        rd_pend_ff;
  logic [5:0]  idx_ff;
  logic        hreadyout_ff;
  logic        hresp_ff;
  logic [31:0] hrdata_ff;
  logic        reg_am_ff;
  logic [5:0]  depth_ff;
  logic [2:0]  drv_norm_ff;
  logic        drv_hiz_ff;
  logic        ext_pin_ff;
  logic        rsam_en_ff;
  logic [6:0]  res_code_ff;
  logic [12:0] tgt_cnorm_ff;
  logic        tgt_hiz_ff;
  logic        tgt_mod_ff;
  logic        accept;
  logic        commit;
  logic        mod_now;
  logic [3:0]  tgt_code;
  logic [5:0]  nxt_depth;
  logic [2:0]  nxt_drv_norm;
  logic        nxt_drv_hiz;
  logic [12:0] nxt_tgt_cnorm;
  logic        nxt_tgt_hiz;
  logic [31:0] nxt_hrdata;

  assign accept   = hsel && hready && htrans[1];
  assign commit   = wr_pend_ff && hready;
  // Driver modulates from the target table only while enabled
  assign mod_now  = aux_mod_ff[txmc_pkg::AUX_DRV_LM] && target_loadmod;
  assign tgt_code = mod_now ? tgt_res_ff[txmc_pkg::TGT_MOD_LSB +: 4] : tgt_res_ff[txmc_pkg::TGT_UNM_LSB +: 4];

  // ----------------------------------------------------------------
  // Decoders
  // ----------------------------------------------------------------
  txmc_decode u_txmc_decode (
    .am_idx    (tx_drv_ff[txmc_pkg::AM_IDX_LSB +: 4]),
    .drv_res   (tx_drv_ff[txmc_pkg::DRV_RES_LSB +: 4]),
    .tgt_code  (tgt_code),
    .depth_pct (nxt_depth),
    .drv_norm  (nxt_drv_norm),
    .drv_hiz   (nxt_drv_hiz),
    .tgt_cnorm (nxt_tgt_cnorm),
    .tgt_hiz   (nxt_tgt_hiz)
  );

  // ----------------------------------------------------------------
  // Bus phases
  // ----------------------------------------------------------------
  // Reads take one wait state so read data always leaves a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff   <= 1'b0;
      rd_pend_ff   <= 1'b0;
      idx_ff       <= 6'h00;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
    end else begin
      hresp_ff <= 1'b0;
      if (hready) begin
        wr_pend_ff <= accept && hwrite && (hsize == txmc_pkg::HSIZE_WORD);
        rd_pend_ff <= accept && !hwrite;
        hreadyout_ff <= !(accept && !hwrite);
        if (accept) begin
          idx_ff <= haddr[7:2];
        end
      end else begin
        rd_pend_ff   <= 1'b0;
        hreadyout_ff <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_drv_ff  <= txmc_pkg::TX_DRV_RST;
      aux_mod_ff <= txmc_pkg::AUX_MOD_RST;
      tgt_res_ff <= txmc_pkg::TGT_RES_RST;
      ram_res_ff <= txmc_pkg::RAM_RES_RST;
      space_b_ff <= 1'b0;
    end else if (commit) begin
      if (idx_ff == txmc_pkg::IDX_SPACE_SEL) begin
        space_b_ff <= hwdata[0];
      end
      if (!space_b_ff) begin
        if (idx_ff == txmc_pkg::IDX_TX_DRV) begin
          tx_drv_ff <= hwdata[7:0];
        end
        if (idx_ff == txmc_pkg::IDX_TGT_RES) begin
          tgt_res_ff <= hwdata[7:0];
        end
      end else begin
        if (idx_ff == txmc_pkg::IDX_AUX_MOD) begin
          aux_mod_ff <= hwdata[7:0] & txmc_pkg::AUX_WR_MASK;
        end
        if (idx_ff == txmc_pkg::IDX_RAM_RES) begin
          ram_res_ff <= hwdata[6:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // Reserved and unmapped words are not decoded, so they read zero
  always_comb begin
    nxt_hrdata = 32'h0000_0000;
    if (idx_ff == txmc_pkg::IDX_SPACE_SEL) begin
      nxt_hrdata = {31'h0000_0000, space_b_ff};
    end else if (idx_ff == txmc_pkg::IDX_STATUS) begin
      nxt_hrdata = {21'h00_0000, tgt_mod_ff, tgt_hiz_ff, ext_pin_ff, drv_hiz_ff, reg_am_ff, depth_ff};
    end else if (!space_b_ff && idx_ff == txmc_pkg::IDX_TX_DRV) begin
      nxt_hrdata = {24'h00_0000, tx_drv_ff};
    end else if (!space_b_ff && idx_ff == txmc_pkg::IDX_TGT_RES) begin
      nxt_hrdata = {24'h00_0000, tgt_res_ff};
    end else if (space_b_ff && idx_ff == txmc_pkg::IDX_AUX_MOD) begin
      nxt_hrdata = {24'h00_0000, aux_mod_ff};
    end else if (space_b_ff && idx_ff == txmc_pkg::IDX_RAM_RES) begin
      nxt_hrdata = {25'h000_0000, ram_res_ff};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (rd_pend_ff) begin
      hrdata_ff <= nxt_hrdata;
    end
  end

  // ----------------------------------------------------------------
  // Modulation controls
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reg_am_ff   <= 1'b0;
      depth_ff    <= 6'h00;
      drv_norm_ff <= 3'h0;
      drv_hiz_ff  <= 1'b0;
    end else begin
      reg_am_ff   <= !aux_mod_ff[txmc_pkg::AUX_REG_DIS];
      depth_ff    <= nxt_depth;
      drv_norm_ff <= nxt_drv_norm;
      drv_hiz_ff  <= nxt_drv_hiz;
    end
  end

  // Pin rests at its inactive level while disabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_pin_ff <= 1'b0;
    end else if (aux_mod_ff[txmc_pkg::AUX_EXT_EN]) begin
      ext_pin_ff <= target_loadmod ^ aux_mod_ff[txmc_pkg::AUX_EXT_POL];
    end else begin
      ext_pin_ff <= aux_mod_ff[txmc_pkg::AUX_EXT_POL];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rsam_en_ff  <= 1'b0;
      res_code_ff <= 7'h00;
    end else begin
      rsam_en_ff  <= aux_mod_ff[txmc_pkg::AUX_RSAM_EN];
      res_code_ff <= aux_mod_ff[txmc_pkg::AUX_RSAM_EN] ? ram_res_ff : 7'h00;
    end
  end

  // Nibbles are taken live; the host must set them before target mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tgt_cnorm_ff <= 13'h0000;
      tgt_hiz_ff   <= 1'b0;
      tgt_mod_ff   <= 1'b0;
    end else begin
      tgt_cnorm_ff <= nxt_tgt_cnorm;
      tgt_hiz_ff   <= nxt_tgt_hiz;
      tgt_mod_ff   <= mod_now;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hreadyout               = hreadyout_ff;
  assign hresp                   = hresp_ff;
  assign hrdata                  = hrdata_ff;
  assign regulator_am_active     = reg_am_ff;
  assign regulator_am_depth_pct  = depth_ff;
  assign driver_res_norm         = drv_norm_ff;
  assign driver_res_hiz          = drv_hiz_ff;
  assign ext_loadmod_pin         = ext_pin_ff;
  assign resistive_am_active     = rsam_en_ff;
  assign resistive_am_resistance = res_code_ff;
  assign target_res_cnorm        = tgt_cnorm_ff;
  assign target_res_hiz          = tgt_hiz_ff;
  assign target_mod_state        = tgt_mod_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_am_depth_top: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (tx_drv_ff[7:4] == 4'd15) ##1 (tx_drv_ff[7:4] == 4'd15) |-> depth_ff == 6'd40)
    else $error("AM depth for code 15 is not 40");

  a_am_depth_low: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (tx_drv_ff[7:4] == 4'd10) |=> depth_ff == 6'd15)
    else $error("AM depth for code 10 is not 15");

  a_drv_res_map: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (tx_drv_ff[3:0] == 4'd15) |=> drv_hiz_ff && drv_norm_ff == 3'd4)
    else $error("Driver code 15 not high impedance");

  a_tx_drv_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    commit && !space_b_ff && idx_ff == 6'h28 |=> tx_drv_ff == $past(hwdata[7:0]))
    else $error("TX driver write lost");

  a_space_route: assert property (
    @(posedge hclk) disable iff (!hresetn)
    commit && space_b_ff && idx_ff == 6'h28 |=> $stable(tx_drv_ff) && aux_mod_ff == ($past(hwdata[7:0]) & 8'hf8))
    else $error("Space B write reached the wrong register");

  a_reg_am_off: assert property (
    @(posedge hclk) disable iff (!hresetn)
    aux_mod_ff[7] |=> !regulator_am_active)
    else $error("Regulator AM active while disabled");

  a_ext_pin_pol: assert property (
    @(posedge hclk) disable iff (!hresetn)
    aux_mod_ff[5] && target_loadmod |=> ext_loadmod_pin == !$past(aux_mod_ff[6]))
    else $error("External pin polarity wrong");

  a_ext_pin_idle: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !aux_mod_ff[5] |=> ext_loadmod_pin == $past(aux_mod_ff[6]))
    else $error("External pin moved while disabled");

  a_drv_lm_off: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !aux_mod_ff[4] |=> !target_mod_state)
    else $error("Driver load modulation while disabled");

  a_rsam_code: assert property (
    @(posedge hclk) disable iff (!hresetn)
    aux_mod_ff[3] |=> resistive_am_active && resistive_am_resistance == $past(ram_res_ff))
    else $error("Resistive AM code not applied");

  a_tgt_hiz_map: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !mod_now && tgt_res_ff[3:0] == 4'd0 |=> target_res_cnorm == 13'd25 && !target_res_hiz)
    else $error("Target code 0 not 0.25");

  a_rsvd_read: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_pend_ff && (idx_ff == 6'h26 || idx_ff == 6'h27) |=> hreadyout && hrdata == 32'h0)
    else $error("Reserved register read not zero");

  a_aux_rsvd: assert property (
    @(posedge hclk) disable iff (!hresetn)
    aux_mod_ff[2:0] == 3'h0)
    else $error("Aux reserved bits set");

endmodule : txmc_regs

`default_nettype wire
